// ===== src/pea_pkg.sv
// Package with the constants and types of the power and energy accumulator.
// How it works
// - Each channel keeps a rolling mean of its latest eight bus and sense samples.
// - Readable results change only when one of three refresh commands or an enabled slow pin edge arrives.
// - Averages are flagged valid only after eight conversion cycles since reset.
// - Each channel steps through four offset-cancel permutation positions, one per conversion.
// - Bus and sense samples are held internally as 17-bit signed values.
// - Unipolar inputs are shown as 16-bit unsigned readable values.
// - Bipolar bus samples are truncated to 16-bit signed for reading.
// - Bidirectional sense reads truncated to 16 bits; power uses all 17 bits.
// - Power is sense times the 14 upper bus bits, a 30-bit signed value.
// - Each channel has a 56-bit accumulator and a 32-bit sample counter.
// - Power and accumulation always use signed arithmetic, whatever the read format.
// - Half-range mode only shifts readable values; power keeps full precision.
// - Each product is added into the channel accumulator, readable after refresh.
// - The accumulator saturates at its limit instead of wrapping.
// - The counter is never cleared automatically when it reaches its limit.
// - Fullness flags at 15/16, 7/8, 3/4 or full for accumulator and counter.
// - Adaptive mode with the slow pin high, outside single-shot eight-times mode, shifts samples by 7, counts 128.
// - Adaptive rates below 1024 SPS scale data and count to mimic 1024 SPS.
// - Adaptive mode is the reset default; refresh on slow pin edges starts disabled.
// - Full refresh clears accumulators and counters and latches; slow pin refresh clears too unless keep is set; the others only latch.
// - Per channel the accumulator may sum sense or bus values instead of power.
// - In single-shot eight-times mode each of the eight samples is accumulated and counted.
package pea_pkg;

    localparam int NCH = 4;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CMD = 12'h004;
    localparam logic [11:0] ADDR_FMT = 12'h008;
    localparam logic [11:0] ADDR_LIMIT = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam logic [11:0] ADDR_CH_BASE = 12'h020;
    localparam logic [11:0] ADDR_CH_END = 12'h0A0;
    localparam logic [2:0] CH_VBUS = 3'h0;
    localparam logic [2:0] CH_VSENSE = 3'h1;
    localparam logic [2:0] CH_VBUS_AVG = 3'h2;
    localparam logic [2:0] CH_VSENSE_AVG = 3'h3;
    localparam logic [2:0] CH_POWER = 3'h4;
    localparam logic [2:0] CH_ACC_LO = 3'h5;
    localparam logic [2:0] CH_ACC_HI = 3'h6;
    localparam logic [2:0] CH_COUNT = 3'h7;
    localparam int CTRL_ADAPT = 0;
    localparam int CTRL_SS8X = 1;
    localparam int CTRL_RATE = 2;
    localparam int CTRL_SLOW_REF = 4;
    localparam int CTRL_SLOW_KEEP = 5;
    localparam int CMD_REFRESH = 0;
    localparam int CMD_REFRESH_V = 1;
    localparam int CMD_REFRESH_G = 2;
    localparam int FMT_SRC = 16;
    localparam logic [5:0] CTRL_RESET = 6'h01;
    localparam logic [23:0] FMT_RESET = 24'h000000;
    localparam logic [3:0] LIMIT_RESET = 4'h0;
    localparam logic [2:0] AVG_CYCLES = 3'h7;
    localparam logic [2:0] SLOW_SHIFT = 3'h7;
    localparam logic signed [55:0] ACC_MAX = 56'sh7FFFFFFFFFFFFF;
    localparam logic signed [55:0] ACC_MIN = 56'sh80000000000000;
    localparam logic [31:0] CNT_MAX = 32'hFFFFFFFF;

    typedef enum logic [1:0] {
        PEA_SRC_POWER,
        PEA_SRC_VSENSE,
        PEA_SRC_VBUS,
        PEA_SRC_OFF
    } pea_src_t;

    typedef struct packed {
        logic [1:0] chan;
        logic signed [16:0] vbus;
        logic signed [16:0] vsense;
    } pea_sample_t;

endpackage : pea_pkg

// ===== src/pea_accumulator.sv
// Result datapath of a four-channel power monitor with an APB register slave.
module pea_accumulator (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_valid,
    input wire pea_pkg::pea_sample_t conv_data,
    input wire logic cycle_done,
    input wire logic slow_pin,
    output logic [7:0] perm_pos
);
    import pea_pkg::*;

    // ------------------------------------------------------------
    // Functions.
    // ------------------------------------------------------------
    function automatic logic [15:0] fmt16(logic signed [16:0] x, logic bip, logic half);
        if (bip && !half) begin
            fmt16 = x[16:1];
        end else begin
            fmt16 = x[15:0];
        end
    endfunction : fmt16

    function automatic logic [55:0] thr_of(logic [55:0] mx, logic [1:0] sel);
        case (sel)
            2'h1: thr_of = mx - (mx >> 4);
            2'h2: thr_of = mx - (mx >> 3);
            2'h3: thr_of = mx - (mx >> 2);
            default: thr_of = mx;
        endcase
    endfunction : thr_of

    function automatic logic signed [55:0] sat_add(logic signed [55:0] a, logic signed [55:0] b);
        logic signed [56:0] s;
        s = {a[55], a} + {b[55], b};
        if (s[56] != s[55]) begin
            sat_add = s[56] ? ACC_MIN : ACC_MAX;
        end else begin
            sat_add = s[55:0];
        end
    endfunction : sat_add

    function automatic logic [31:0] cnt_add(logic [31:0] a, logic [2:0] sh);
        logic [32:0] s;
        s = {1'b0, a} + (33'h1 << sh);
        cnt_add = s[32] ? CNT_MAX : s[31:0];
    endfunction : cnt_add

    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    logic [5:0] ctrl_reg;
    logic [23:0] fmt_reg;
    logic [3:0] limit_reg;
    logic slow_s1_reg;
    logic slow_s2_reg;
    logic slow_q_reg;
    logic [2:0] cyc_reg;
    logic avg_valid_reg;
    logic [NCH-1:0] acc_full_reg;
    logic [NCH-1:0] cnt_full_reg;
    logic signed [16:0] hist_vb [NCH][8];
    logic signed [16:0] hist_vs [NCH][8];
    logic [2:0] hidx_reg [NCH];
    logic signed [19:0] sum_vb_reg [NCH];
    logic signed [19:0] sum_vs_reg [NCH];
    logic signed [16:0] live_vb_reg [NCH];
    logic signed [16:0] live_vs_reg [NCH];
    logic signed [29:0] live_pwr_reg [NCH];
    logic signed [55:0] acc_reg [NCH];
    logic [31:0] cnt_reg [NCH];
    logic [15:0] rd_vb_reg [NCH];
    logic [15:0] rd_vs_reg [NCH];
    logic [15:0] rd_vba_reg [NCH];
    logic [15:0] rd_vsa_reg [NCH];
    logic [29:0] rd_pwr_reg [NCH];
    logic [55:0] rd_acc_reg [NCH];
    logic [31:0] rd_cnt_reg [NCH];

    // ------------------------------------------------------------
    // Bus decode and command strobes.
    // ------------------------------------------------------------
    logic access;
    logic wr_en;
    logic cmd_wr;
    logic slow_evt;
    logic latch;
    logic clr;
    logic [2:0] shamt;
    logic signed [30:0] prod;
    logic signed [29:0] pwr30;
    logic signed [55:0] add_val;
    logic [1:0] sch;
    pea_src_t src;
    logic [1:0] rch;

    assign access = ce && psel && penable && pready;
    assign wr_en = access && pwrite;
    assign cmd_wr = wr_en && (paddr == ADDR_CMD);
    assign slow_evt = ctrl_reg[CTRL_SLOW_REF] && (slow_s2_reg != slow_q_reg);
    assign latch = (cmd_wr && (|pwdata[CMD_REFRESH_G:CMD_REFRESH])) || slow_evt;
    assign clr = (cmd_wr && pwdata[CMD_REFRESH]) || (slow_evt && !ctrl_reg[CTRL_SLOW_KEEP]);
    // Channel blocks start one block above address zero, so the block index is offset by one.
    assign rch = paddr[6:5] - 2'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && penable && !pready) begin
                if (paddr[1:0] != 2'h0) begin
                    pslverr <= 1'b1;
                end else if (paddr == ADDR_CTRL) begin
                    prdata <= {26'h0000000, ctrl_reg};
                end else if (paddr == ADDR_CMD) begin
                    prdata <= 32'h00000000;
                end else if (paddr == ADDR_FMT) begin
                    prdata <= {8'h00, fmt_reg};
                end else if (paddr == ADDR_LIMIT) begin
                    prdata <= {28'h0000000, limit_reg};
                end else if (paddr == ADDR_STATUS) begin
                    prdata <= {20'h00000, cnt_full_reg, acc_full_reg, 2'h0,
                        slow_s2_reg, avg_valid_reg};
                end else if (paddr >= ADDR_CH_BASE && paddr < ADDR_CH_END) begin
                    case (paddr[4:2])
                        CH_VBUS: prdata <= {16'h0000, rd_vb_reg[rch]};
                        CH_VSENSE: prdata <= {16'h0000, rd_vs_reg[rch]};
                        CH_VBUS_AVG: prdata <= {16'h0000, rd_vba_reg[rch]};
                        CH_VSENSE_AVG: prdata <= {16'h0000, rd_vsa_reg[rch]};
                        CH_POWER: prdata <= {{2{rd_pwr_reg[rch][29]}}, rd_pwr_reg[rch]};
                        CH_ACC_LO: prdata <= rd_acc_reg[rch][31:0];
                        CH_ACC_HI: prdata <= {8'h00, rd_acc_reg[rch][55:32]};
                        default: prdata <= rd_cnt_reg[rch];
                    endcase
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers.
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
            fmt_reg <= FMT_RESET;
            limit_reg <= LIMIT_RESET;
        end else if (wr_en) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_reg <= pwdata[5:0];
            end else if (paddr == ADDR_FMT) begin
                fmt_reg <= pwdata[23:0];
            end else if (paddr == ADDR_LIMIT) begin
                limit_reg <= pwdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Slow pin synchroniser and average warm-up.
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_s1_reg <= 1'b0;
            slow_s2_reg <= 1'b0;
            slow_q_reg <= 1'b0;
        end else if (ce) begin
            slow_s1_reg <= slow_pin;
            slow_s2_reg <= slow_s1_reg;
            slow_q_reg <= slow_s2_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_reg <= 3'h0;
            avg_valid_reg <= 1'b0;
        end else if (ce && cycle_done && !avg_valid_reg) begin
            cyc_reg <= cyc_reg + 3'h1;
            avg_valid_reg <= (cyc_reg == AVG_CYCLES);
        end
    end

    // ------------------------------------------------------------
    // Sample arithmetic.
    // ------------------------------------------------------------
    always_comb begin
        sch = conv_data.chan;
        src = pea_src_t'(fmt_reg[FMT_SRC + 2*sch +: 2]);
        prod = conv_data.vsense * $signed(conv_data.vbus[16:3]);
        pwr30 = prod[29:0];
        shamt = 3'h0;
        if (ctrl_reg[CTRL_ADAPT] && !ctrl_reg[CTRL_SS8X]) begin
            if (slow_s2_reg) begin
                shamt = SLOW_SHIFT;
            end else begin
                shamt = {ctrl_reg[CTRL_RATE+1:CTRL_RATE], 1'b0};
            end
        end
        case (src)
            PEA_SRC_VSENSE: add_val = 56'(conv_data.vsense);
            PEA_SRC_VBUS: add_val = 56'(conv_data.vbus);
            PEA_SRC_OFF: add_val = 56'sh0;
            default: add_val = 56'(pwr30);
        endcase
        add_val = add_val <<< shamt;
    end

    // ------------------------------------------------------------
    // Per-channel datapath.
    // ------------------------------------------------------------
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_ch
            logic hit;
            logic signed [55:0] acc_base;
            logic [31:0] cnt_base;
            assign hit = ce && conv_valid && (sch == 2'(c));
            assign acc_base = clr ? 56'sh0 : acc_reg[c];
            assign cnt_base = clr ? 32'h00000000 : cnt_reg[c];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    perm_pos[2*c +: 2] <= 2'h0;
                    hidx_reg[c] <= 3'h0;
                    sum_vb_reg[c] <= 20'sh0;
                    sum_vs_reg[c] <= 20'sh0;
                    live_vb_reg[c] <= 17'sh0;
                    live_vs_reg[c] <= 17'sh0;
                    live_pwr_reg[c] <= 30'sh0;
                    for (int i = 0; i < 8; i++) begin
                        hist_vb[c][i] <= 17'sh0;
                        hist_vs[c][i] <= 17'sh0;
                    end
                end else if (hit) begin
                    perm_pos[2*c +: 2] <= perm_pos[2*c +: 2] + 2'h1;
                    live_vb_reg[c] <= conv_data.vbus;
                    live_vs_reg[c] <= conv_data.vsense;
                    live_pwr_reg[c] <= pwr30;
                    hist_vb[c][hidx_reg[c]] <= conv_data.vbus;
                    hist_vs[c][hidx_reg[c]] <= conv_data.vsense;
                    hidx_reg[c] <= hidx_reg[c] + 3'h1;
                    sum_vb_reg[c] <= sum_vb_reg[c] + 20'(conv_data.vbus)
                        - 20'(hist_vb[c][hidx_reg[c]]);
                    sum_vs_reg[c] <= sum_vs_reg[c] + 20'(conv_data.vsense)
                        - 20'(hist_vs[c][hidx_reg[c]]);
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    acc_reg[c] <= 56'sh0;
                    cnt_reg[c] <= 32'h00000000;
                end else if (ce) begin
                    if (hit && src != PEA_SRC_OFF) begin
                        acc_reg[c] <= sat_add(acc_base, add_val);
                        cnt_reg[c] <= cnt_add(cnt_base, shamt);
                    end else begin
                        acc_reg[c] <= acc_base;
                        cnt_reg[c] <= cnt_base;
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    acc_full_reg[c] <= 1'b0;
                    cnt_full_reg[c] <= 1'b0;
                end else if (ce) begin
                    acc_full_reg[c] <= acc_reg[c] >= $signed(thr_of(ACC_MAX, limit_reg[1:0]));
                    cnt_full_reg[c] <= {24'h000000, cnt_reg[c]} >=
                        thr_of({24'h000000, CNT_MAX}, limit_reg[3:2]);
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rd_vb_reg[c] <= 16'h0000;
                    rd_vs_reg[c] <= 16'h0000;
                    rd_vba_reg[c] <= 16'h0000;
                    rd_vsa_reg[c] <= 16'h0000;
                    rd_pwr_reg[c] <= 30'h00000000;
                    rd_acc_reg[c] <= 56'h0;
                    rd_cnt_reg[c] <= 32'h00000000;
                end else if (ce && latch) begin
                    rd_vb_reg[c] <= fmt16(live_vb_reg[c], fmt_reg[4*c],
                        fmt_reg[4*c+2]);
                    rd_vs_reg[c] <= fmt16(live_vs_reg[c], fmt_reg[4*c+1],
                        fmt_reg[4*c+3]);
                    rd_vba_reg[c] <= fmt16(sum_vb_reg[c][19:3], fmt_reg[4*c], fmt_reg[4*c+2]);
                    rd_vsa_reg[c] <= fmt16(sum_vs_reg[c][19:3], fmt_reg[4*c+1],
                        fmt_reg[4*c+3]);
                    rd_pwr_reg[c] <= live_pwr_reg[c];
                    rd_acc_reg[c] <= acc_reg[c];
                    rd_cnt_reg[c] <= cnt_reg[c];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic hit0;
    assign hit0 = ce && conv_valid && sch == 2'h0 && src != PEA_SRC_OFF;

    property p_ready;
        ce && psel && penable && !pready |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("Ready did not follow access.");

    property p_stable_rd;
        !(ce && latch) |=> $stable(rd_acc_reg[0]) && $stable(rd_cnt_reg[0]);
    endproperty
    a_stable_rd: assert property (p_stable_rd) else $error("Readable changed without refresh.");

    property p_clear;
        ce && clr && !hit0 |=> acc_reg[0] == 56'sh0 && cnt_reg[0] == 32'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("Full refresh did not clear.");

    property p_latch_cnt;
        ce && latch |=> rd_cnt_reg[0] == $past(cnt_reg[0]);
    endproperty
    a_latch_cnt: assert property (p_latch_cnt) else $error("Count not latched.");

    property p_avg_warm;
        $rose(avg_valid_reg) |-> $past(cyc_reg) == 3'h7;
    endproperty
    a_avg_warm: assert property (p_avg_warm) else $error("Average valid too early.");

    property p_perm;
        ce && conv_valid && sch == 2'h0 |=> perm_pos[1:0] == $past(perm_pos[1:0]) + 2'h1;
    endproperty
    a_perm: assert property (p_perm) else $error("Permutation did not step.");

    property p_slow128;
        hit0 && !clr && ctrl_reg[0] && !ctrl_reg[1] && slow_s2_reg && cnt_reg[0] < 32'hFFFFFF00
            |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h80;
    endproperty
    a_slow128: assert property (p_slow128) else $error("Slow count step not 128.");

    property p_one;
        hit0 && !clr && !ctrl_reg[0] && cnt_reg[0] != CNT_MAX
            |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h1;
    endproperty
    a_one: assert property (p_one) else $error("Count step not one.");

    property p_cnt_hold;
        cnt_reg[0] == CNT_MAX && !(ce && clr) |=> cnt_reg[0] == CNT_MAX;
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("Counter wrapped.");

    property p_acc_hold;
        acc_reg[0] == ACC_MAX && !(ce && clr) && src != PEA_SRC_VSENSE
            && !(hit0 && add_val[55]) |=> acc_reg[0] == ACC_MAX;
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("Accumulator wrapped.");

    c_refresh: cover property (ce && clr ##1 ce && latch);
    c_slow: cover property (hit0 && slow_s2_reg);
    c_valid: cover property ($rose(avg_valid_reg));

endmodule : pea_accumulator

// ===== tb/pea_host.sv
// Host model that runs APB transfers towards the accumulator.
module pea_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    // Request is held until pready is seen high at a rising edge, or for at most 50 edges.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic to);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        to = (n >= 50);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : pea_host

// ===== tb/power_energy_accumulator_tb.sv
// Self-checking testbench of the accumulator datapath.
module power_energy_accumulator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pea_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic conv_valid, cycle_done, slow_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] perm_pos;
    pea_sample_t conv_data;
    int fails = 0;
    int samples_checked = 0;
    pea_accumulator dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
        .conv_data(conv_data), .cycle_done(cycle_done), .slow_pin(slow_pin),
        .perm_pos(perm_pos));
    pea_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("BAD at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        logic to;
        host.xfer(w, a, d, r, e, to);
        if (to) begin
            fails++;
            wrap_up();
        end
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        bus(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        bus(1'b0, a, 32'h00000000, r, e);
        chk(r & m, x);
    endtask : rd
    task automatic rde(input logic [11:0] a);
        logic [31:0] r;
        logic e;
        bus(1'b0, a, 32'h00000000, r, e);
        chk({31'h00000000, e}, 32'h00000001);
    endtask : rde
    function automatic logic [11:0] ca(input logic [2:0] k);
        return ADDR_CH_BASE + {7'h00, k, 2'h0};
    endfunction : ca
    task automatic send(input logic [16:0] vb, input logic [16:0] vs);
        @(posedge pclk);
        conv_valid <= 1'b1;
        conv_data <= '{chan: 2'h0, vbus: vb, vsense: vs};
        @(posedge pclk);
        conv_valid <= 1'b0;
        cycle_done <= 1'b1;
        @(posedge pclk);
        cycle_done <= 1'b0;
    endtask : send
    task automatic acc_is(input logic [31:0] a, input logic [31:0] c);
        wr(ADDR_CMD, 32'h00000002);
        rd(ca(CH_ACC_LO), 32'hFFFFFFFF, a);
        rd(ca(CH_COUNT), 32'hFFFFFFFF, c);
    endtask : acc_is
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        conv_valid = 1'b0;
        conv_data = '0;
        cycle_done = 1'b0;
        slow_pin = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CTRL, 32'hFFFFFFFF, 32'h00000001);
        rd(ADDR_FMT, 32'hFFFFFFFF, 32'h00000000);
        rde(12'h014);
        rde(12'h002);
        wr(ADDR_LIMIT, 32'h0000000F);
        rd(ADDR_LIMIT, 32'hFFFFFFFF, 32'h0000000F);
        rd(ADDR_STATUS, 32'h00000FF0, 32'h00000000);
        $display("test reset done");
        repeat (7) send(17'h00010, 17'h00000);
        rd(ADDR_STATUS, 32'h00000001, 32'h00000000);
        chk({30'h0, perm_pos[1:0]}, 32'h00000003);
        send(17'h00010, 17'h00000);
        rd(ADDR_STATUS, 32'h00000001, 32'h00000001);
        chk({30'h0, perm_pos[1:0]}, 32'h00000000);
        wr(ADDR_CMD, 32'h00000004);
        rd(ca(CH_VBUS_AVG), 32'h0000FFFF, 32'h00000010);
        rd(ca(CH_VBUS), 32'h0000FFFF, 32'h00000010);
        $display("test average done");
        wr(ADDR_CMD, 32'h00000001);
        acc_is(32'h00000000, 32'h00000000);
        send(17'h00800, 17'h00003);
        send(17'h00800, 17'h00003);
        rd(ca(CH_ACC_LO), 32'hFFFFFFFF, 32'h00000000);
        acc_is(32'h00000600, 32'h00000002);
        rd(ca(CH_VBUS_AVG), 32'h0000FFFF, 32'h0000020C);
        rd(ca(CH_POWER), 32'hFFFFFFFF, 32'h00000300);
        wr(ADDR_CMD, 32'h00000001);
        rd(ca(CH_ACC_LO), 32'hFFFFFFFF, 32'h00000600);
        acc_is(32'h00000000, 32'h00000000);
        $display("test power done");
        wr(ADDR_FMT, 32'h00000002);
        send(17'h00800, 17'h10001);
        acc_is(32'hFF000100, 32'h00000001);
        rd(ca(CH_ACC_HI), 32'hFFFFFFFF, 32'h00FFFFFF);
        rd(ca(CH_VSENSE), 32'h0000FFFF, 32'h00008000);
        rd(ca(CH_POWER), 32'hFFFFFFFF, 32'hFF000100);
        wr(ADDR_FMT, 32'h0000000B);
        wr(ADDR_CMD, 32'h00000002);
        rd(ca(CH_VSENSE), 32'h0000FFFF, 32'h00000001);
        rd(ca(CH_POWER), 32'hFFFFFFFF, 32'hFF000100);
        wr(ADDR_FMT, 32'h00000001);
        wr(ADDR_CMD, 32'h00000002);
        rd(ca(CH_VBUS), 32'h0000FFFF, 32'h00000400);
        wr(ADDR_FMT, 32'h00000000);
        $display("test format done");
        wr(ADDR_CMD, 32'h00000001);
        slow_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(ADDR_STATUS, 32'h00000002, 32'h00000002);
        rd(ca(CH_ACC_LO), 32'hFFFFFFFF, 32'hFF000100);
        send(17'h00800, 17'h00003);
        acc_is(32'h00018000, 32'h00000080);
        wr(ADDR_CMD, 32'h00000001);
        wr(ADDR_CTRL, 32'h00000000);
        send(17'h00800, 17'h00003);
        acc_is(32'h00000300, 32'h00000001);
        slow_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        wr(ADDR_CMD, 32'h00000001);
        wr(ADDR_CTRL, 32'h00000005);
        send(17'h00800, 17'h00003);
        acc_is(32'h00000C00, 32'h00000004);
        wr(ADDR_CMD, 32'h00000001);
        wr(ADDR_CTRL, 32'h00000003);
        repeat (8) send(17'h00800, 17'h00003);
        acc_is(32'h00001800, 32'h00000008);
        $display("test adaptive done");
        wr(ADDR_CTRL, 32'h00000001);
        wr(ADDR_FMT, 32'h00010000);
        wr(ADDR_CMD, 32'h00000001);
        send(17'h00800, 17'h00005);
        acc_is(32'h00000005, 32'h00000001);
        wr(ADDR_FMT, 32'h00020000);
        wr(ADDR_CMD, 32'h00000001);
        send(17'h00800, 17'h00005);
        acc_is(32'h00000800, 32'h00000001);
        ce <= 1'b0;
        send(17'h00800, 17'h00005);
        ce <= 1'b1;
        acc_is(32'h00000800, 32'h00000001);
        wr(ADDR_FMT, 32'h00030000);
        send(17'h00800, 17'h00005);
        acc_is(32'h00000800, 32'h00000001);
        $display("test source done");
        wr(ADDR_FMT, 32'h00000000);
        wr(ADDR_CTRL, 32'h00000031);
        send(17'h00800, 17'h00003);
        slow_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(ca(CH_COUNT), 32'hFFFFFFFF, 32'h00000002);
        wr(ADDR_CTRL, 32'h00000011);
        slow_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(ca(CH_ACC_LO), 32'hFFFFFFFF, 32'h00000B00);
        acc_is(32'h00000000, 32'h00000000);
        $display("test slow refresh done");
        wrap_up();
    end
endmodule : power_energy_accumulator_tb
